// ===== logic/pgc_gpio.v
// Packet-commanded five-pin GPIO block with AHB-Lite command port
// Operation
// - Set-pin command 0x22 takes two bytes, or three to also set function and drive
// - First byte is pin index; 0-4 are pins, 5-255 address nothing
// - Value 0 low, 1-99 PWM duty at 100 Hz, 100 high, above invalid
// - Drive modes set per-level strong, slow, resistive or high-Z drive
// - Drive mode 110 is reserved and rejected with an error reply
// - Function 0 gives default role, 1 gives user GPIO control
// - Accepted set-pin replies 0x62 with empty payload
// - Store-boot command 0x04 captures configuration; reset returns the boot copy to defaults
// - Read-pin command 0x23 carries one pin index byte
// - Read reply 0x63 has four bytes, first echoes index
// - Reply byte 1 bit 0 is sampled pin level
// - Reply byte 1 bit 1 marks a falling edge since last poll
// - Reply byte 1 bit 2 marks a rising edge since last poll
// - Edges are seen only through periodic samples
// - Reply byte 2 returns the commanded level or duty
// - Reply byte 3 returns function and drive mode, upper bits zero
// - Default roles: power sense, power control, reset control, one-wire line
// - Every pin sampled at 32 Hz; level and edges come from samples
`timescale 1ns/1ps
`include "pgc_regs.vh"
module pgc_gpio #(
  parameter [31:0] SMP_CYC = `PGC_SMP_CYC,      // Cycles per input sample tick
  parameter [31:0] PWM_CYC = `PGC_PWM_STEP_CYC  // Cycles per PWM duty step
) (
  input  wire        hclk,           // Bus clock, 100 MHz
  input  wire        hresetn,        // Asynchronous reset, active low
  input  wire        hsel,           // Slave select
  input  wire [31:0] haddr,          // Byte address
  input  wire [1:0]  htrans,         // Transfer type
  input  wire        hwrite,         // Write strobe
  input  wire [2:0]  hsize,          // Transfer size
  input  wire        hready,         // Bus ready in
  input  wire [31:0] hwdata,         // Write data
  output reg  [31:0] hrdata,         // Read data
  output reg         hreadyout,      // Slave ready
  output reg         hresp,          // Always OKAY
  input  wire [4:0]  pin_in,         // Pin levels from pads
  output reg  [4:0]  pin_out,        // Pin drive value
  output reg  [4:0]  pin_oe_n,       // Pin drive enable, low drives
  output reg  [4:0]  pin_pull_up,    // Resistive pull-up enable
  output reg  [4:0]  pin_pull_dn,    // Resistive pull-down enable
  output reg  [4:0]  pin_slow,       // Slow slew select
  output reg  [4:0]  user_gpio,      // Pin under user control
  output reg         host_pwr_ctl,   // Default-role host power control
  output reg         host_rst_ctl,   // Default-role host reset control
  output reg         host_pwr_sense, // Default-role sampled host power sense
  output reg         one_wire_sensor_line_in // Default-role sampled one-wire level
);

  //////////////////////////////////////////////////////////////////////////////
  // Counter end points; both periods fit in 24 bits
  localparam [23:0] PWM_LAST = PWM_CYC[23:0] - 24'h000001;
  localparam [23:0] SMP_LAST = SMP_CYC[23:0] - 24'h000001;

  reg [31:0] aw_addr_r;
  reg        aw_wr_r;
  reg [7:0]  cmd_r;
  reg [7:0]  arg0_r, arg1_r, arg2_r;
  reg        go_r;
  reg [7:0]  rsp_code_r;
  reg [31:0] rsp_data_r;
  reg        rsp_valid_r;
  reg [7:0]  lvl_r [0:4];
  reg [7:0]  fdb_r [0:4];
  reg [7:0]  boot_lvl_r [0:4];
  reg [7:0]  boot_fdb_r [0:4];
  reg        boot_ld_r;
  reg [4:0]  s1_r, s2_r, s3_r;
  reg [4:0]  lvl_s_r, fall_r, rise_r;
  reg [23:0] smp_cnt_r, pwm_cnt_r;
  reg [6:0]  pwm_pos_r;
  reg        smp_tick;
  reg        primed_r;
  integer    j;
  integer    k;
  integer    m;

  function pin_ok;
    input [7:0] idx;
    begin
      pin_ok = (idx < `PGC_NPINS);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait-free cycle per transfer
  wire acc = hsel & hready & htrans[1];
  // Only the lowest 256 bytes decode; anything above reads zero, writes are dropped
  wire in_map = (haddr[31:8] == 24'h000000);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_addr_r <= 32'h00000000;
      aw_wr_r   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      aw_wr_r <= acc & hwrite & in_map;
      if (acc)
        aw_addr_r <= haddr;
      if (acc & ~hwrite & ~in_map)
        hrdata <= 32'h00000000;
      if (acc & ~hwrite & in_map) begin
        case (haddr[7:0])
          `PGC_A_CMD:  hrdata <= {24'h000000, cmd_r};
          `PGC_A_ARG0: hrdata <= {24'h000000, arg0_r};
          `PGC_A_ARG1: hrdata <= {24'h000000, arg1_r};
          `PGC_A_ARG2: hrdata <= {24'h000000, arg2_r};
          `PGC_A_RSP0: hrdata <= {24'h000000, rsp_code_r};
          `PGC_A_RSP1: hrdata <= rsp_data_r;
          `PGC_A_STAT: hrdata <= {30'h00000000, go_r, rsp_valid_r};
          default:     hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command execution
  wire wr_cmd = aw_wr_r & (aw_addr_r[7:0] == `PGC_A_CMD);
  wire [2:0] ai = arg0_r[2:0];
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= 8'h00;
      arg0_r <= 8'h00;
      arg1_r <= 8'h00;
      arg2_r <= 8'h00;
      go_r <= 1'b0;
      rsp_code_r <= 8'h00;
      rsp_data_r <= 32'h00000000;
      rsp_valid_r <= 1'b0;
      // Boot image is copied into the live settings on the first cycle after reset
      boot_ld_r <= 1'b1;
      rise_r <= 5'h00;
      fall_r <= 5'h00;
      for (i = 0; i < 5; i = i + 1) begin
        lvl_r[i] <= `PGC_DEF_LVL;
        fdb_r[i] <= `PGC_DEF_FDB;
        boot_lvl_r[i] <= `PGC_DEF_LVL;
        boot_fdb_r[i] <= `PGC_DEF_FDB;
      end
    end else begin
      if (boot_ld_r) begin
        boot_ld_r <= 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
          lvl_r[i] <= boot_lvl_r[i];
          fdb_r[i] <= boot_fdb_r[i];
        end
      end
      if (aw_wr_r) begin
        case (aw_addr_r[7:0])
          `PGC_A_ARG0: arg0_r <= hwdata[7:0];
          `PGC_A_ARG1: arg1_r <= hwdata[7:0];
          `PGC_A_ARG2: arg2_r <= hwdata[7:0];
          `PGC_A_STAT: if (hwdata[0]) rsp_valid_r <= 1'b0;
          default: ;
        endcase
      end
      if (wr_cmd) begin
        cmd_r <= hwdata[7:0];
        go_r  <= 1'b1;
      end
      // Edges set by samples win over poll clear
      for (i = 0; i < 5; i = i + 1) begin
        if (smp_tick && primed_r && s2_r[i] == s3_r[i] && s2_r[i] != lvl_s_r[i]) begin
          if (s2_r[i]) rise_r[i] <= 1'b1;
          else fall_r[i] <= 1'b1;
        end else if (go_r && cmd_r == `PGC_CMD_READ && pin_ok(arg0_r) && ai == i) begin
          rise_r[i] <= 1'b0;
          fall_r[i] <= 1'b0;
        end
      end
      if (go_r) begin
        go_r <= 1'b0;
        rsp_valid_r <= 1'b1;
        rsp_data_r <= 32'h00000000;
        rsp_code_r <= `PGC_RSP_ERR;
        case (cmd_r)
          `PGC_CMD_SET: begin
            // arg2 bit 7 set means three-byte form
            if (pin_ok(arg0_r) && arg1_r <= `PGC_LVL_HIGH &&
                (!arg2_r[7] || (arg2_r[6:0] <= `PGC_FDB_MAX &&
                                arg2_r[2:0] != `PGC_MODE_RSVD))) begin
              lvl_r[ai] <= arg1_r;
              if (arg2_r[7])
                fdb_r[ai] <= {4'h0, arg2_r[3:0]};
              rsp_code_r <= `PGC_RSP_SET;
            end
          end
          `PGC_CMD_READ: begin
            if (pin_ok(arg0_r)) begin
              rsp_code_r <= `PGC_RSP_READ;
              rsp_data_r <= {fdb_r[ai] & 8'h0f, lvl_r[ai],
                             5'h00, rise_r[ai], fall_r[ai], lvl_s_r[ai], arg0_r};
            end
          end
          `PGC_CMD_STORE: begin
            for (i = 0; i < 5; i = i + 1) begin
              boot_lvl_r[i] <= lvl_r[i];
              boot_fdb_r[i] <= fdb_r[i];
            end
            rsp_code_r <= `PGC_RSP_STORE;
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 32 Hz sampler with three-stage synchroniser
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      lvl_s_r <= 5'h00;
      primed_r <= 1'b0;
      smp_cnt_r <= 24'h000000;
      smp_tick <= 1'b0;
      host_pwr_sense <= 1'b0;
      one_wire_sensor_line_in <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      smp_tick <= (smp_cnt_r == SMP_LAST);
      smp_cnt_r <= (smp_cnt_r == SMP_LAST) ? 24'h000000 : smp_cnt_r + 24'h000001;
      // First tick only loads the levels, so a pin idling high after reset
      // is not reported as a rising edge
      if (smp_tick) begin
        primed_r <= 1'b1;
        for (j = 0; j < 5; j = j + 1)
          if (s2_r[j] == s3_r[j]) lvl_s_r[j] <= s2_r[j];
      end
      host_pwr_sense <= lvl_s_r[1];
      one_wire_sensor_line_in <= lvl_s_r[4];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 100 Hz PWM in 100 steps, then drive-mode decode
  reg [4:0] val;
  always @* begin
    for (m = 0; m < 5; m = m + 1)
      val[m] = ({1'b0, pwm_pos_r} < lvl_r[m]);
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_cnt_r <= 24'h000000;
      pwm_pos_r <= 7'h00;
      pin_out <= 5'h00;
      pin_oe_n <= 5'h1f;
      pin_pull_up <= 5'h00;
      pin_pull_dn <= 5'h00;
      pin_slow <= 5'h00;
      user_gpio <= 5'h00;
      host_pwr_ctl <= 1'b0;
      host_rst_ctl <= 1'b0;
    end else begin
      if (pwm_cnt_r == PWM_LAST) begin
        pwm_cnt_r <= 24'h000000;
        pwm_pos_r <= (pwm_pos_r == 7'd99) ? 7'h00 : pwm_pos_r + 7'h01;
      end else
        pwm_cnt_r <= pwm_cnt_r + 24'h000001;
      for (k = 0; k < 5; k = k + 1) begin
        user_gpio[k] <= fdb_r[k][`PGC_FUNC_BIT];
        pin_out[k] <= val[k];
        pin_pull_up[k] <= 1'b0;
        pin_pull_dn[k] <= 1'b0;
        pin_slow[k] <= fdb_r[k][2];
        // Pulls only ever act on an undriven pin, never against the driver
        case (fdb_r[k][2:0])
          3'h0: begin
            pin_oe_n[k] <= ~val[k];
            pin_pull_dn[k] <= ~val[k];
          end
          3'h1: pin_oe_n[k] <= 1'b0;
          3'h2: pin_oe_n[k] <= 1'b1;
          3'h3: begin
            pin_oe_n[k] <= val[k];
            pin_pull_up[k] <= val[k];
          end
          3'h4: pin_oe_n[k] <= ~val[k];
          3'h5: pin_oe_n[k] <= 1'b0;
          3'h7: pin_oe_n[k] <= val[k];
          // Reserved mode leaves the pin undriven
          default: pin_oe_n[k] <= 1'b1;
        endcase
      end
      host_pwr_ctl <= ~fdb_r[2][`PGC_FUNC_BIT] & val[2];
      host_rst_ctl <= ~fdb_r[3][`PGC_FUNC_BIT] & val[3];
    end
  end

endmodule // pgc_gpio

// ===== logic/pgc_regs.vh
// Register offsets, field positions, reset values and timing counts of the packet GPIO block
`ifndef PGC_REGS_VH
`define PGC_REGS_VH
`define PGC_CMD_SET        8'h22
`define PGC_CMD_READ       8'h23
`define PGC_CMD_STORE      8'h04
`define PGC_RSP_SET        8'h62
`define PGC_RSP_READ       8'h63
`define PGC_RSP_STORE      8'h44
`define PGC_RSP_ERR        8'hc0
`define PGC_NPINS          5
`define PGC_LVL_HIGH       8'h64
`define PGC_FDB_MAX        8'h0f
`define PGC_MODE_RSVD      3'h6
`define PGC_FUNC_BIT       3
`define PGC_CLK_HZ         100000000
`define PGC_PWM_HZ         100
`define PGC_SMP_HZ         32
`define PGC_PWM_STEP_CYC   (`PGC_CLK_HZ / (`PGC_PWM_HZ * 100))
`define PGC_SMP_CYC        (`PGC_CLK_HZ / `PGC_SMP_HZ)
`define PGC_A_CMD          32'h00000000
`define PGC_A_ARG0         32'h00000004
`define PGC_A_ARG1         32'h00000008
`define PGC_A_ARG2         32'h0000000c
`define PGC_A_RSP0         32'h00000010
`define PGC_A_RSP1         32'h00000014
`define PGC_A_STAT         32'h00000018
`define PGC_DEF_LVL        8'h00
`define PGC_DEF_FDB        8'h02
`endif

// ===== verif/pgc_gpio_monitor.sv
// Bus and pad assertions for the packet GPIO block
`timescale 1ns/1ps
`include "pgc_regs.vh"
module pgc_gpio_monitor #(
  parameter int SMP = `PGC_SMP_CYC          // Cycles per sample tick
) (
  input wire        hclk,                   // Clock
  input wire        hresetn,                // Reset
  input wire        hsel,                   // Select
  input wire [31:0] haddr,                  // Address
  input wire [1:0]  htrans,                 // Transfer
  input wire        hwrite,                 // Write
  input wire        hready,                 // Ready in
  input wire [31:0] hrdata,                 // Read data
  input wire        hreadyout,              // Ready out
  input wire        hresp,                  // Response
  input wire [4:0]  pin_oe_n,               // Drive enable
  input wire [4:0]  pin_pull_up,            // Pull-up
  input wire [4:0]  pin_pull_dn,            // Pull-down
  input wire        host_pwr_sense,         // Sampled pin 1
  input wire        one_wire_sensor_line_in // Sampled pin 4
);
  logic [1:0]  smp_r;
  logic [21:0] gap_r;
  wire  [1:0]  smp_now = {host_pwr_sense, one_wire_sensor_line_in};
  wire         rd_req  = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////////
  // Cycles since the sampled levels last moved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_r <= 2'h0;
      gap_r <= 22'h3fffff;
    end else begin
      smp_r <= smp_now;
      gap_r <= (smp_now != smp_r) ? 22'h0 : gap_r + {21'h0, gap_r != 22'h3fffff};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Error response seen");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("Wait state seen");
  a_rdata_holds: assert property (!$past(rd_req) |-> $stable(hrdata))
    else $error("Read data moved without a read");
  a_unmapped_zero: assert property (rd_req && haddr >= 32'h1c |=> hrdata == 32'h0)
    else $error("Unmapped read not zero");
  a_pullup_undriven: assert property ((pin_pull_up & ~pin_oe_n) == 5'h0)
    else $error("Pull-up while driving");
  a_pulldn_undriven: assert property ((pin_pull_dn & ~pin_oe_n) == 5'h0)
    else $error("Pull-down while driving");
  a_pulls_exclusive: assert property ((pin_pull_up & pin_pull_dn) == 5'h0)
    else $error("Both pulls on");
  a_sample_spacing: assert property (smp_now != smp_r |-> gap_r >= SMP - 1)
    else $error("Sampled level moved between ticks");
endmodule // pgc_gpio_monitor
bind pgc_gpio pgc_gpio_monitor #(.SMP(SMP_CYC)) mon (.*);

// ===== verif/pgc_pad_model.sv
// Pad model resolving each GPIO wire from drive and pulls
`timescale 1ns/1ps
module pgc_pad_model (
  input  wire        hclk,        // Clock
  input  wire        hresetn,     // Reset
  input  wire [4:0]  pin_out,     // Drive value
  input  wire [4:0]  pin_oe_n,    // Low drives
  input  wire [4:0]  pin_pull_up, // Pull-up
  input  wire [4:0]  pin_pull_dn, // Pull-down
  output logic [4:0] pin_in       // Wire levels
);
  logic flt_r;
  // Floating wires wander so no stale level is read
  always @(posedge hclk or negedge hresetn) begin
    flt_r <= hresetn ? ~flt_r : 1'b0;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else if (pin_pull_dn[i]) pin_in[i] = 1'b0;
      else if (i == 4) pin_in[i] = 1'b1;         // Board pull-up
      else pin_in[i] = flt_r;
    end
  end
endmodule // pgc_pad_model

// ===== verif/tb.sv
// Self-checking bench for the packet GPIO block
`timescale 1ns/1ps
`include "pgc_regs.vh"
module tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd, code, data;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, host_pwr_ctl, host_rst_ctl, host_pwr_sense;
  wire         one_wire_sensor_line_in;
  wire  [4:0]  pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_dn, pin_slow, user_gpio;
  wire         hready = hreadyout;
  int          num_errors, checks, n;
  localparam int SMP = 64;
  logic [2:0]  modes[7] = '{0, 1, 2, 3, 4, 5, 7};
  logic [23:0] bad[5] = '{24'h006589, 24'h00648e, 24'h006490, 24'h056489, 24'hff6489};
  pgc_gpio #(.SMP_CYC(SMP), .PWM_CYC(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn),
    .pin_slow(pin_slow), .user_gpio(user_gpio), .host_pwr_ctl(host_pwr_ctl),
    .host_rst_ctl(host_rst_ctl), .host_pwr_sense(host_pwr_sense),
    .one_wire_sensor_line_in(one_wire_sensor_line_in));
  pgc_pad_model pad (
    .hclk(hclk), .hresetn(hresetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .pin_in(pin_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [7:0] c, i, v, f);
    xfer(1'b1, `PGC_A_ARG0, {24'h0, i});
    xfer(1'b1, `PGC_A_ARG1, {24'h0, v});
    xfer(1'b1, `PGC_A_ARG2, {24'h0, f});
    xfer(1'b1, `PGC_A_CMD, {24'h0, c});
    rd = '0;
    while (rd[0] !== 1'b1) xfer(1'b0, `PGC_A_STAT, 32'h0);
    xfer(1'b0, `PGC_A_RSP0, 32'h0);
    code = rd;
    xfer(1'b0, `PGC_A_RSP1, 32'h0);
    data = rd;
    xfer(1'b1, `PGC_A_STAT, 32'h1);
  endtask
  task automatic end_of_test;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    cmd(`PGC_CMD_READ, 8'h2, 8'h0, 8'h0);
    chk(code, {24'h0, `PGC_RSP_READ});
    chk(data & 32'hfffff8ff, {`PGC_DEF_FDB, `PGC_DEF_LVL, 16'h0002});
    chk({host_pwr_ctl, host_rst_ctl}, 32'h0);
    cmd(`PGC_CMD_SET, 8'h2, `PGC_LVL_HIGH, 8'h0);
    chk({host_pwr_ctl, host_rst_ctl}, 32'h2);
    $display("test boot_readback done");
    foreach (modes[k]) begin
      cmd(`PGC_CMD_SET, 8'h0, `PGC_LVL_HIGH, {5'h11, modes[k]});
      chk(code, {24'h0, `PGC_RSP_SET});
      chk({user_gpio[0], pin_oe_n[0], pin_pull_up[0], pin_out[0] | pin_oe_n[0], pin_slow[0]},
          {1'b1, !(modes[k] inside {0, 1, 4, 5}), modes[k] == 3, 1'b1,
           modes[k] inside {4, 5, 7}});
      cmd(`PGC_CMD_SET, 8'h0, 8'h0, 8'h0);
      chk(code, {24'h0, `PGC_RSP_SET});
      chk({pin_oe_n[0], pin_pull_dn[0], pin_out[0] & !pin_oe_n[0]},
          {!(modes[k] inside {1, 3, 5, 7}), modes[k] == 0, 1'b0});
      cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
      chk(data & 32'hffff00ff, {5'h01, modes[k], 24'h0});
    end
    $display("test drive_modes done");
    cmd(`PGC_CMD_SET, 8'h0, 8'h32, 8'h89);
    chk(code, {24'h0, `PGC_RSP_SET});
    foreach (bad[k]) begin
      cmd(`PGC_CMD_SET, bad[k][23:16], bad[k][15:8], bad[k][7:0]);
      chk(code, {24'h0, `PGC_RSP_ERR});
    end
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    chk(data[31:16], 32'h0932);
    $display("test rejects done");
    n = 0;
    repeat (200) begin
      @(posedge hclk);
      n += pin_out[0];
    end
    chk(n, 32'd100);
    cmd(`PGC_CMD_SET, 8'h0, `PGC_LVL_HIGH, 8'h89);
    repeat (3 * SMP) @(posedge hclk);
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    chk(data[15:8], 32'h01);
    cmd(`PGC_CMD_SET, 8'h0, 8'h0, 8'h0);
    repeat (3 * SMP) @(posedge hclk);
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    chk(data[15:8], 32'h02);
    cmd(`PGC_CMD_SET, 8'h0, `PGC_LVL_HIGH, 8'h0);
    repeat (3 * SMP) @(posedge hclk);
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    chk(data[15:8], 32'h05);
    cmd(`PGC_CMD_READ, 8'h4, 8'h0, 8'h0);
    chk(data[15:0], 32'h0104);
    chk({host_pwr_sense, one_wire_sensor_line_in}, 32'h1);
    $display("test pin_sampling done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    cmd(`PGC_CMD_READ, 8'h0, 8'h0, 8'h0);
    chk(data & 32'hfffff8ff, {`PGC_DEF_FDB, `PGC_DEF_LVL, 16'h0000});
    $display("test mid_reset done");
    xfer(1'b1, 32'h1c, 32'hffffffff);
    xfer(1'b0, 32'h1c, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 32'h104, 32'h0);
    chk(rd, 32'h0);
    cmd(`PGC_CMD_STORE, 8'h0, 8'h0, 8'h0);
    chk(code, {24'h0, `PGC_RSP_STORE});
    $display("test store_unmapped done");
    end_of_test;
  end
  initial begin
    #500000;
    num_errors++;
    end_of_test;
  end
endmodule // tb
